// file: src/cgs_regs.sv
// page-0 status, alarm, mask and device control register bank
`timescale 1ns/10ps
module cgs_regs (
   input  wire logic              mclk,
   input  wire logic              rst,
   input  wire cgs_pkg::cgs_req_t req,
   output logic [7:0]             rd_data,
   output logic                   rd_valid,
   input  wire cgs_pkg::cgs_alarm_t alarm_async,
   input  wire logic              address_select_pin_high,
   input  wire logic              address_select_pin_low,
   input  wire logic              ref_choice_pin_high,
   input  wire logic              ref_choice_pin_low,
   output logic [6:0]             serial_address,
   output logic [1:0]             ref_choice,
   output logic                   low_power_request,
   output logic                   hard_reset_level,
   output logic                   nvm_reload,
   output logic                   soft_reset_pulse,
   output logic                   freq_step_up,
   output logic                   freq_step_down,
   output logic                   divider_sync,
   output logic                   irq
);

   // synchroniser stages; stage one feeds only stage two
   cgs_pkg::cgs_alarm_t alarm_s1_r;
   cgs_pkg::cgs_alarm_t alarm_r;
   logic [3:0]          pins_s1_r;
   logic [3:0]          pins_r;

   // register state
   logic [7:0]          page_r;
   logic [4:0]          ser_addr_r;
   logic [7:0]          stat_flag_r;
   logic [7:0]          stat_flag_nxt;
   logic [3:0]          inloss_flag_r;
   logic [3:0]          inloss_flag_nxt;
   logic [7:0]          stat_mask_r;
   logic [3:0]          inloss_mask_r;
   logic [1:0]          pwr_r;
   logic [2:0]          ref_sel_r;
   logic [1:0]          fstep_r;
   logic                hard_prev_r;

   // decoded access
   logic                on_page0;
   logic                wr_page0;
   logic [7:0]          live_vec;
   logic [3:0]          inloss_vec;
   logic [7:0]          rd_nxt;

   // true when the enable is set and the address equals the given offset
   function automatic logic hit(input logic [7:0] off, input logic [7:0] a, input logic en);
      hit = en && (a == off);
   endfunction

   // two-flop synchronisers for alarms and pins
   always_ff @(posedge mclk) begin
      if (rst) begin
         alarm_s1_r <= '0;
         alarm_r    <= '0;
         pins_s1_r  <= 4'h0;
         pins_r     <= 4'h0;
      end else begin
         alarm_s1_r <= alarm_async;
         alarm_r    <= alarm_s1_r;
         pins_s1_r  <= {address_select_pin_high, address_select_pin_low, ref_choice_pin_high, ref_choice_pin_low};
         pins_r     <= pins_s1_r;
      end
   end

   // page-zero qualifiers; the page register itself answers on every page
   assign on_page0 = (page_r == cgs_pkg::PAGE_ZERO);
   assign wr_page0 = req.wr && on_page0;

   // live status word laid out at its documented bit positions
   always_comb begin
      live_vec                          = 8'h00;
      live_vec[cgs_pkg::ST_CAL]         = alarm_r.calibrating_status;
      live_vec[cgs_pkg::ST_XTAL]        = alarm_r.crystal_signal_loss;
      live_vec[cgs_pkg::ST_REF]         = alarm_r.reference_missing;
      live_vec[cgs_pkg::ST_UNLOCK]      = alarm_r.unlocked_status;
      live_vec[cgs_pkg::ST_TIMEOUT]     = alarm_r.bus_timeout;
   end
   assign inloss_vec = alarm_r.input_signal_loss;

   // page register, present on every page
   always_ff @(posedge mclk) begin
      if (rst) begin
         page_r <= cgs_pkg::PAGE_RST;
      end else if (hit(cgs_pkg::OFF_PAGE, req.addr, req.wr)) begin
         page_r <= req.wdata;
      end
   end

   // serial address upper field
   always_ff @(posedge mclk) begin
      if (rst) begin
         ser_addr_r <= cgs_pkg::SER_ADDR_RST;
      end else if (hit(cgs_pkg::OFF_SER_ADDR, req.addr, wr_page0)) begin
         ser_addr_r <= req.wdata[cgs_pkg::SER_ADDR_MSB:cgs_pkg::SER_ADDR_LSB];
      end
   end

   // full seven-bit address: register upper part, pin lower part
   always_ff @(posedge mclk) begin
      if (rst) begin
         serial_address <= 7'h00;
      end else begin
         serial_address <= {ser_addr_r, pins_r[3], pins_r[2]};
      end
   end

   // sticky next values: a write of 0 clears, a live condition sets and wins
   always_comb begin
      stat_flag_nxt   = stat_flag_r;
      inloss_flag_nxt = inloss_flag_r;
      if (soft_reset_pulse) begin
         stat_flag_nxt   = cgs_pkg::FLAG_RST;
         inloss_flag_nxt = 4'h0;
      end
      if (hit(cgs_pkg::OFF_LATCHED, req.addr, wr_page0)) begin
         stat_flag_nxt = stat_flag_r & req.wdata;
      end
      if (hit(cgs_pkg::OFF_INLOSS_LAT, req.addr, wr_page0)) begin
         inloss_flag_nxt = inloss_flag_r & req.wdata[3:0];
      end
      stat_flag_nxt   = (stat_flag_nxt | live_vec) & cgs_pkg::STATUS_USED;
      inloss_flag_nxt = inloss_flag_nxt | inloss_vec;
   end

   // sticky flag registers
   always_ff @(posedge mclk) begin
      if (rst) begin
         stat_flag_r   <= cgs_pkg::FLAG_RST;
         inloss_flag_r <= 4'h0;
      end else begin
         stat_flag_r   <= stat_flag_nxt;
         inloss_flag_r <= inloss_flag_nxt;
      end
   end

   // interrupt mask registers
   always_ff @(posedge mclk) begin
      if (rst) begin
         stat_mask_r   <= cgs_pkg::MASK_RST;
         inloss_mask_r <= 4'h0;
      end else begin
         if (hit(cgs_pkg::OFF_STAT_MASK, req.addr, wr_page0)) begin
            stat_mask_r <= req.wdata & cgs_pkg::STATUS_USED;
         end
         if (hit(cgs_pkg::OFF_INLOSS_MASK, req.addr, wr_page0)) begin
            inloss_mask_r <= req.wdata[3:0];
         end
      end
   end

   // interrupt: any latched flag whose mask bit is clear
   always_ff @(posedge mclk) begin
      if (rst) begin
         irq <= 1'b0;
      end else begin
         irq <= (|(stat_flag_r & ~stat_mask_r)) |
                (|(inloss_flag_r & ~inloss_mask_r));
      end
   end

   // soft reset: one-cycle action, the bit never reads back as 1
   always_ff @(posedge mclk) begin
      if (rst) begin
         soft_reset_pulse <= 1'b0;
      end else begin
         soft_reset_pulse <= hit(cgs_pkg::OFF_SOFT_RST, req.addr, wr_page0) &&
                             req.wdata[cgs_pkg::SOFT_RST_BIT];
      end
   end

   // frequency step bits: write stores, next cycle clears; rising edge fires
   always_ff @(posedge mclk) begin
      if (rst) begin
         fstep_r        <= 2'h0;
         freq_step_up   <= 1'b0;
         freq_step_down <= 1'b0;
      end else begin
         if (hit(cgs_pkg::OFF_FSTEP, req.addr, wr_page0)) begin
            fstep_r <= {req.wdata[cgs_pkg::FREQ_STEP_DOWN_BIT], req.wdata[cgs_pkg::FREQ_STEP_UP_BIT]};
         end else begin
            fstep_r <= 2'h0;
         end
         freq_step_up   <= hit(cgs_pkg::OFF_FSTEP, req.addr, wr_page0) &&
                           req.wdata[cgs_pkg::FREQ_STEP_UP_BIT] && !fstep_r[0];
         freq_step_down <= hit(cgs_pkg::OFF_FSTEP, req.addr, wr_page0) &&
                           req.wdata[cgs_pkg::FREQ_STEP_DOWN_BIT] && !fstep_r[1];
      end
   end

   // power down and hard reset are plain stored bits; sync is a pulse
   always_ff @(posedge mclk) begin
      if (rst) begin
         pwr_r        <= cgs_pkg::PWR_RST;
         divider_sync <= 1'b0;
      end else begin
         divider_sync <= 1'b0;
         if (hit(cgs_pkg::OFF_PWR_CTRL, req.addr, wr_page0)) begin
            pwr_r        <= {req.wdata[cgs_pkg::HARD_RST_BIT], req.wdata[cgs_pkg::PDN_BIT]};
            divider_sync <= req.wdata[cgs_pkg::SYNC_BIT];
         end
      end
   end

   // hard reset level, and a reload request on its rising edge
   always_ff @(posedge mclk) begin
      if (rst) begin
         hard_prev_r       <= 1'b0;
         nvm_reload        <= 1'b0;
         low_power_request <= 1'b0;
         hard_reset_level  <= 1'b0;
      end else begin
         hard_prev_r       <= pwr_r[1];
         nvm_reload        <= pwr_r[1] && !hard_prev_r;
         low_power_request <= pwr_r[0];
         hard_reset_level  <= pwr_r[1];
      end
   end

   // reference input selection register
   always_ff @(posedge mclk) begin
      if (rst) begin
         ref_sel_r <= cgs_pkg::REF_SEL_RST;
      end else if (hit(cgs_pkg::OFF_REF_SEL, req.addr, wr_page0)) begin
         ref_sel_r <= req.wdata[cgs_pkg::SEL_MSB:cgs_pkg::SEL_REG_BIT];
      end
   end

   // effective reference: pins or register field
   always_ff @(posedge mclk) begin
      if (rst) begin
         ref_choice <= 2'h0;
      end else if (ref_sel_r[cgs_pkg::SEL_REG_BIT]) begin
         ref_choice <= ref_sel_r[cgs_pkg::SEL_MSB:cgs_pkg::SEL_LSB];
      end else begin
         ref_choice <= pins_r[1:0];
      end
   end

   // read multiplexer; other pages show only the page register
   always_comb begin
      rd_nxt = 8'h00;
      if (req.addr == cgs_pkg::OFF_PAGE) begin
         rd_nxt = page_r;
      end else if (on_page0) begin
         unique case (req.addr)
            cgs_pkg::OFF_SER_ADDR:    rd_nxt = {1'b0, ser_addr_r, 2'b00};
            cgs_pkg::OFF_LIVE:        rd_nxt = live_vec;
            cgs_pkg::OFF_INLOSS_LIVE: rd_nxt = {4'h0, inloss_vec};
            cgs_pkg::OFF_LATCHED:     rd_nxt = stat_flag_r;
            cgs_pkg::OFF_INLOSS_LAT:  rd_nxt = {4'h0, inloss_flag_r};
            cgs_pkg::OFF_STAT_MASK:   rd_nxt = stat_mask_r;
            cgs_pkg::OFF_INLOSS_MASK: rd_nxt = {4'h0, inloss_mask_r};
            cgs_pkg::OFF_FSTEP:       rd_nxt = {6'h00, fstep_r};
            cgs_pkg::OFF_PWR_CTRL:    rd_nxt = {6'h00, pwr_r};
            cgs_pkg::OFF_REF_SEL:     rd_nxt = {5'h00, ref_sel_r};
            default:                  rd_nxt = 8'h00;  // soft reset and unused read 0
         endcase
      end
   end

   // registered read answer, one cycle after the request
   always_ff @(posedge mclk) begin
      if (rst) begin
         rd_data  <= 8'h00;
         rd_valid <= 1'b0;
      end else begin
         rd_valid <= req.rd;
         if (req.rd) begin
            rd_data <= rd_nxt;
         end
      end
   end

endmodule // cgs_regs

// file: src/cgs_pkg.sv
// package: offsets, field positions, reset values and carriers for the page-0 status/control bank
package cgs_pkg;

   // register offsets within a page
   localparam logic [7:0] OFF_PAGE        = 8'h01;
   localparam logic [7:0] OFF_SER_ADDR    = 8'h0B;
   localparam logic [7:0] OFF_LIVE        = 8'h0C;
   localparam logic [7:0] OFF_INLOSS_LIVE = 8'h0D;
   localparam logic [7:0] OFF_LATCHED     = 8'h11;
   localparam logic [7:0] OFF_INLOSS_LAT  = 8'h12;
   localparam logic [7:0] OFF_STAT_MASK   = 8'h17;
   localparam logic [7:0] OFF_INLOSS_MASK = 8'h18;
   localparam logic [7:0] OFF_SOFT_RST    = 8'h1C;
   localparam logic [7:0] OFF_FSTEP       = 8'h1D;
   localparam logic [7:0] OFF_PWR_CTRL    = 8'h1E;
   localparam logic [7:0] OFF_REF_SEL     = 8'h21;

   // the only page every register but the page register answers on
   localparam logic [7:0] PAGE_ZERO       = 8'h00;

   // field positions
   localparam int SER_ADDR_LSB   = 2;
   localparam int SER_ADDR_MSB   = 6;
   localparam int ST_CAL         = 0;
   localparam int ST_XTAL        = 1;
   localparam int ST_REF         = 2;
   localparam int ST_UNLOCK      = 3;
   localparam int ST_TIMEOUT     = 5;
   localparam int SOFT_RST_BIT   = 0;
   localparam int FREQ_STEP_UP_BIT       = 0;
   localparam int FREQ_STEP_DOWN_BIT       = 1;
   localparam int PDN_BIT        = 0;
   localparam int HARD_RST_BIT   = 1;
   localparam int SYNC_BIT       = 2;
   localparam int SEL_REG_BIT    = 0;
   localparam int SEL_LSB        = 1;
   localparam int SEL_MSB        = 2;

   // used bits of the status-shaped registers
   localparam logic [7:0] STATUS_USED = 8'h2F;
   localparam logic [7:0] INLOSS_USED = 8'h0F;

   // values after reset
   localparam logic [7:0] PAGE_RST     = 8'h00;
   localparam logic [4:0] SER_ADDR_RST = 5'h1D;  // arbitrary neutral default
   localparam logic [7:0] MASK_RST     = 8'h00;
   localparam logic [7:0] FLAG_RST     = 8'h00;
   localparam logic [2:0] REF_SEL_RST  = 3'h0;
   localparam logic [1:0] PWR_RST      = 2'h0;

   // one register access from the serial management engine
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } cgs_req_t;

   // live alarm conditions from the analog and loop logic
   typedef struct packed {
      logic       bus_timeout;
      logic       unlocked_status;
      logic       reference_missing;
      logic       crystal_signal_loss;
      logic       calibrating_status;
      logic [3:0] input_signal_loss;  // feedback, two, one, zero
   } cgs_alarm_t;

endpackage

// file: tb/cgs_regs_chk.sv
// port checks for the page-0 status and control bank
`timescale 1ns/10ps
module cgs_regs_chk (
   input wire logic              mclk,
   input wire logic              rst,
   input wire cgs_pkg::cgs_req_t req,
   input wire logic [7:0]        rd_data,
   input wire logic              address_select_pin_high,
   input wire logic              address_select_pin_low,
   input wire logic              ref_choice_pin_high,
   input wire logic              ref_choice_pin_low,
   input wire logic [6:0]        serial_address,
   input wire logic [1:0]        ref_choice,
   input wire logic              low_power_request,
   input wire logic              hard_reset_level,
   input wire logic              nvm_reload,
   input wire logic              soft_reset_pulse,
   input wire logic              freq_step_up,
   input wire logic              freq_step_down,
   input wire logic              divider_sync,
   input wire logic              irq
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   logic [7:0] page_r;
   logic [7:0] smask_r;
   logic [7:0] imask_r;
   logic [2:0] sel_r;
   logic [4:0] upper_r;
   logic       w0, fs_wr, pw_wr, fu, fd;
   // write decodes on page zero
   assign w0 = req.wr && page_r == cgs_pkg::PAGE_ZERO;
   assign fs_wr = w0 && req.addr == cgs_pkg::OFF_FSTEP;
   assign pw_wr = w0 && req.addr == cgs_pkg::OFF_PWR_CTRL;
   assign fu = fs_wr && req.wdata[cgs_pkg::FREQ_STEP_UP_BIT];
   assign fd = fs_wr && req.wdata[cgs_pkg::FREQ_STEP_DOWN_BIT];
   // shadow of host-written control state
   always_ff @(posedge mclk) begin
      if (rst) begin
         page_r <= cgs_pkg::PAGE_RST;
         smask_r <= cgs_pkg::MASK_RST;
         imask_r <= cgs_pkg::MASK_RST;
         sel_r <= cgs_pkg::REF_SEL_RST;
         upper_r <= cgs_pkg::SER_ADDR_RST;
      end else begin
         if (req.wr && req.addr == cgs_pkg::OFF_PAGE) page_r <= req.wdata;
         if (w0 && req.addr == cgs_pkg::OFF_STAT_MASK) smask_r <= req.wdata & cgs_pkg::STATUS_USED;
         if (w0 && req.addr == cgs_pkg::OFF_INLOSS_MASK) imask_r <= req.wdata & cgs_pkg::INLOSS_USED;
         if (w0 && req.addr == cgs_pkg::OFF_REF_SEL) sel_r <= req.wdata[2:0];
         if (w0 && req.addr == cgs_pkg::OFF_SER_ADDR) upper_r <= req.wdata[6:2];
      end
   end
   // a strobe that lasts exactly one cycle
   sequence one_pulse(sig);
      sig ##1 !sig;
   endsequence
   addr_map_a: assert property (
      $stable({upper_r, address_select_pin_high, address_select_pin_low}) [*6] |->
      serial_address == {upper_r, address_select_pin_high, address_select_pin_low})
      else $error("serial address does not follow field and pins");
   soft_pulse_a: assert property (
      w0 && req.addr == cgs_pkg::OFF_SOFT_RST && req.wdata[0] |=> one_pulse(soft_reset_pulse))
      else $error("soft reset pulse missing");
   step_up_a: assert property (fu && !$past(fu) |=> freq_step_up)
      else $error("step up pulse missing");
   step_down_a: assert property (freq_step_down |-> $past(fd))
      else $error("step down pulse without a write");
   sync_pulse_a: assert property (pw_wr && req.wdata[cgs_pkg::SYNC_BIT] |=> one_pulse(divider_sync))
      else $error("divider sync pulse missing");
   power_down_a: assert property (
      pw_wr ##1 !pw_wr |=> low_power_request == $past(req.wdata[cgs_pkg::PDN_BIT], 2))
      else $error("low power level wrong");
   hard_pulse_a: assert property (
      pw_wr && !$past(pw_wr) && req.wdata[cgs_pkg::HARD_RST_BIT] && !hard_reset_level |-> ##2 one_pulse(nvm_reload))
      else $error("reload pulse missing");
   hard_hold_a: assert property (hard_reset_level && !pw_wr && !$past(pw_wr) |=> hard_reset_level)
      else $error("hard reset cleared itself");
   irq_mask_a: assert property (
      (smask_r == cgs_pkg::STATUS_USED && imask_r == cgs_pkg::INLOSS_USED) [*3] |-> !irq)
      else $error("interrupt while all masked");
   ref_pick_a: assert property (
      $stable({sel_r, ref_choice_pin_high, ref_choice_pin_low}) [*5] |->
      ref_choice == (sel_r[0] ? sel_r[2:1] : {ref_choice_pin_high, ref_choice_pin_low}))
      else $error("reference choice wrong");
   page_refuse_a: assert property (
      req.rd && page_r != cgs_pkg::PAGE_ZERO && req.addr != cgs_pkg::OFF_PAGE |=> rd_data == 8'h00)
      else $error("bank answered off page zero");
endmodule // cgs_regs_chk
bind cgs_regs cgs_regs_chk u_chk (.mclk(mclk), .rst(rst), .req(req), .rd_data(rd_data),
   .address_select_pin_high(address_select_pin_high), .address_select_pin_low(address_select_pin_low),
   .ref_choice_pin_high(ref_choice_pin_high), .ref_choice_pin_low(ref_choice_pin_low),
   .serial_address(serial_address), .ref_choice(ref_choice), .low_power_request(low_power_request),
   .hard_reset_level(hard_reset_level), .nvm_reload(nvm_reload), .soft_reset_pulse(soft_reset_pulse),
   .freq_step_up(freq_step_up), .freq_step_down(freq_step_down), .divider_sync(divider_sync), .irq(irq));

// file: tb/cgs_host.sv
// host model driving register strobes on the falling edge
`timescale 1ns/10ps
module cgs_host (
   input  wire logic        mclk,
   output cgs_pkg::cgs_req_t req,
   input  wire logic [7:0]  rd_data
);
   initial req = '0;
   // one write: address and data held with wr for one cycle, then wr drops
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge mclk);
      req.wr = 1'b1;
      req.addr = a;
      req.wdata = d;
      @(negedge mclk);
      req.wr = 1'b0;
      req.wdata = ~d;  // stale data never looks valid
   endtask
   // one read, data taken while the answer stands
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge mclk);
      req.rd = 1'b1;
      req.addr = a;
      @(negedge mclk);
      req.rd = 1'b0;
      d = rd_data;
   endtask
endmodule // cgs_host

// file: tb/test_cgs_regs.sv
// self-checking bench for the page-0 status and control bank
`timescale 1ns/10ps
module test_cgs_regs;
   logic                mclk, rst, rd_valid, a_hi, a_lo, r_hi, r_lo;
   logic                lp, hrd, nvm, srp, fup, fdn, dsy, irq;
   cgs_pkg::cgs_req_t   req;
   cgs_pkg::cgs_alarm_t alarm;
   logic [7:0]          rd_data, v;
   logic [6:0]          sa;
   logic [1:0]          rc;
   int                  miscompares = 0, n_compared = 0, cyc = 0;
   cgs_host host (.mclk(mclk), .req(req), .rd_data(rd_data));
   cgs_regs dut (.mclk(mclk), .rst(rst), .req(req), .rd_data(rd_data), .rd_valid(rd_valid),
      .alarm_async(alarm), .address_select_pin_high(a_hi), .address_select_pin_low(a_lo),
      .ref_choice_pin_high(r_hi), .ref_choice_pin_low(r_lo), .serial_address(sa), .ref_choice(rc),
      .low_power_request(lp), .hard_reset_level(hrd), .nvm_reload(nvm), .soft_reset_pulse(srp),
      .freq_step_up(fup), .freq_step_down(fdn), .divider_sync(dsy), .irq(irq));
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      n_compared++;
      if (g !== e) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic bchk(input string nm, input logic e, input logic g);
      chk(nm, {7'h00, e}, {7'h00, g});
   endtask
   task automatic rchk(input string nm, input logic [7:0] a, input logic [7:0] e);
      host.rd(a, v);
      chk(nm, e, v);
      bchk("rd_valid", 1'b1, rd_valid);
   endtask
   task automatic idle(input int n);
      repeat (n) @(negedge mclk);
   endtask
   task automatic results;
      $display("compared %0d mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // reset values of six stored registers
   task automatic t_reset;
      rchk("ser_addr", cgs_pkg::OFF_SER_ADDR, {1'b0, cgs_pkg::SER_ADDR_RST, 2'b00});
      rchk("stat_mask", cgs_pkg::OFF_STAT_MASK, cgs_pkg::MASK_RST);
      rchk("in_mask", cgs_pkg::OFF_INLOSS_MASK, cgs_pkg::MASK_RST);
      rchk("latched", cgs_pkg::OFF_LATCHED, cgs_pkg::FLAG_RST);
      rchk("ref_sel", cgs_pkg::OFF_REF_SEL, {5'h00, cgs_pkg::REF_SEL_RST});
      rchk("page", cgs_pkg::OFF_PAGE, cgs_pkg::PAGE_RST);
      $display("reset test done");
   endtask
   // each status alarm alone, input losses together; latching, clearing and masking
   task automatic t_alarm;
      logic [7:0] b, e;
      e = 8'h00;
      for (int i = 0; i < 5; i++) begin
         b = (i == 4) ? 8'h20 : 8'h01 << i;
         e = e | b;
         alarm = 9'h010 << i;
         idle(4);
         rchk("live", cgs_pkg::OFF_LIVE, b);
         bchk("irq_on", 1'b1, irq);
         alarm = '0;
         idle(4);
         rchk("live_gone", cgs_pkg::OFF_LIVE, 8'h00);
         rchk("latched", cgs_pkg::OFF_LATCHED, e);
      end
      host.wr(cgs_pkg::OFF_LATCHED, 8'h2E);
      rchk("latched_clr", cgs_pkg::OFF_LATCHED, 8'h2E);
      alarm = 9'h00F;
      idle(4);
      rchk("in_live", cgs_pkg::OFF_INLOSS_LIVE, 8'h0F);
      alarm = 9'h005;
      idle(4);
      rchk("in_live_drop", cgs_pkg::OFF_INLOSS_LIVE, 8'h05);
      host.wr(cgs_pkg::OFF_INLOSS_LAT, 8'h08);
      rchk("in_latched", cgs_pkg::OFF_INLOSS_LAT, 8'h0D);
      host.wr(cgs_pkg::OFF_STAT_MASK, 8'h2F);
      host.wr(cgs_pkg::OFF_INLOSS_MASK, 8'h0F);
      idle(3);
      bchk("irq_masked", 1'b0, irq);
      host.wr(cgs_pkg::OFF_INLOSS_MASK, 8'h0E);
      idle(3);
      bchk("irq_in0", 1'b1, irq);
      host.wr(cgs_pkg::OFF_INLOSS_MASK, 8'h0F);
      host.wr(cgs_pkg::OFF_STAT_MASK, 8'h0F);
      idle(3);
      bchk("irq_timeout", 1'b1, irq);
      alarm = '0;
      idle(4);
      host.wr(cgs_pkg::OFF_LATCHED, 8'h00);
      host.wr(cgs_pkg::OFF_INLOSS_LAT, 8'h00);
      host.wr(cgs_pkg::OFF_STAT_MASK, 8'h00);
      host.wr(cgs_pkg::OFF_INLOSS_MASK, 8'h00);
      idle(3);
      bchk("irq_off", 1'b0, irq);
      $display("alarm test done");
   endtask
   // self-clearing actions, power and hard reset
   task automatic t_ctrl;
      alarm = 9'h100;
      idle(4);
      alarm = '0;
      idle(4);
      host.wr(cgs_pkg::OFF_SOFT_RST, 8'h01);
      bchk("soft_pulse", 1'b1, srp);
      rchk("soft_reg", cgs_pkg::OFF_SOFT_RST, 8'h00);
      rchk("soft_flags", cgs_pkg::OFF_LATCHED, 8'h00);
      host.wr(cgs_pkg::OFF_FSTEP, 8'h01);
      bchk("step_up", 1'b1, fup);
      host.wr(cgs_pkg::OFF_FSTEP, 8'h02);
      bchk("step_down", 1'b1, fdn);
      rchk("fstep_reg", cgs_pkg::OFF_FSTEP, 8'h00);
      host.wr(cgs_pkg::OFF_PWR_CTRL, 8'h04);
      bchk("sync", 1'b1, dsy);
      host.wr(cgs_pkg::OFF_PWR_CTRL, 8'h01);
      idle(2);
      bchk("low_power", 1'b1, lp);
      host.wr(cgs_pkg::OFF_PWR_CTRL, 8'h02);
      idle(1);
      bchk("nvm_reload", 1'b1, nvm);
      idle(6);
      bchk("hard_held", 1'b1, hrd);
      bchk("power_back", 1'b0, lp);
      host.wr(cgs_pkg::OFF_PWR_CTRL, 8'h00);
      idle(2);
      bchk("hard_free", 1'b0, hrd);
      $display("control test done");
   endtask
   // reference choice and serial address sources
   task automatic t_sel;
      r_hi = 1'b1;
      a_hi = 1'b1;
      idle(5);
      chk("ref_pins", 8'h02, {6'h00, rc});
      for (int s = 0; s < 4; s++) begin
         host.wr(cgs_pkg::OFF_REF_SEL, 8'(s * 2 + 1));
         idle(3);
         chk("ref_reg", 8'(s), {6'h00, rc});
      end
      r_hi = 1'b0;
      r_lo = 1'b1;
      a_lo = 1'b1;
      host.wr(cgs_pkg::OFF_REF_SEL, 8'h00);
      idle(5);
      chk("ref_pins_low", 8'h01, {6'h00, rc});
      host.wr(cgs_pkg::OFF_SER_ADDR, 8'h54);
      idle(3);
      chk("serial_address", 8'h57, {1'b0, sa});
      $display("select test done");
   endtask
   // other page and unused offset refused
   task automatic t_page;
      host.wr(cgs_pkg::OFF_STAT_MASK, 8'h01);
      host.wr(cgs_pkg::OFF_PAGE, 8'h01);
      rchk("page", cgs_pkg::OFF_PAGE, 8'h01);
      rchk("mask_page1", cgs_pkg::OFF_STAT_MASK, 8'h00);
      host.wr(cgs_pkg::OFF_STAT_MASK, 8'h02);
      host.wr(cgs_pkg::OFF_PAGE, 8'h00);
      rchk("mask_page0", cgs_pkg::OFF_STAT_MASK, 8'h01);
      rchk("unused", 8'h0E, 8'h00);
      $display("page test done");
   endtask
   // 25 MHz clock
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end
   // hang guard
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 5000) begin
         miscompares++;
         results;
      end
   end
   initial begin
      rst = 1'b1;
      alarm = '0;
      {a_hi, a_lo, r_hi, r_lo} = 4'h0;
      idle(2);
      rst = 1'b0;
      t_reset;
      t_alarm;
      t_ctrl;
      t_sel;
      t_page;
      results;
   end
endmodule // test_cgs_regs
